// ===== pkg/ccco_regs.vh
// constants for the clear, complement and call execution block
`ifndef CCCO_REGS_VH
`define CCCO_REGS_VH
`define CCCO_OP_NONE 3'h0
`define CCCO_OP_CLRWD 3'h1
`define CCCO_OP_CALLACC 3'h2
`define CCCO_OP_COMPF 3'h3
`define CCCO_OP_CLRFILE 3'h4
`define CCCO_OP_CLRACC 3'h5
`define CCCO_OP_DECFILE 3'h6
`define CCCO_ZERO_BYTE 8'h00
`define CCCO_PC_RST 15'h0000
`define CCCO_ACC_RST 8'h00
`define CCCO_CALL_CYCLES 2'h2
`define CCCO_DEST_ACC 1'b0
`define CCCO_DEST_FILE 1'b1
`endif

// ===== src/ccco_alu.v
// alu for complement and decrement with zero detection
`timescale 1ns/100ps
`include "ccco_regs.vh"
module ccco_alu (
  input wire [2:0] op,
  input wire [7:0] operand,
  output reg [7:0] result,
  output wire zero
);
  always @* begin
    case (op)
      `CCCO_OP_COMPF: result = ~operand;
      `CCCO_OP_DECFILE: result = operand - 8'h01;
      default: result = `CCCO_ZERO_BYTE;
    endcase
  end
  assign zero = (result == `CCCO_ZERO_BYTE);
endmodule

// ===== src/ccco_exec.v
// execution unit for clear watchdog, call via accumulator, complement, clear and decrement
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "ccco_regs.vh"
module ccco_exec (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire [6:0] file_addr,
  input wire dest_sel,
  input wire [7:0] file_rdata,
  input wire [6:0] pc_high_latch,
  input wire [14:0] pc_in,
  output reg op_ready,
  output reg [7:0] accumulator,
  output reg [14:0] pc_out,
  output reg pc_load,
  output reg file_we,
  output reg [6:0] file_waddr,
  output reg [7:0] file_wdata,
  output reg [14:0] stack_top,
  output reg stack_push,
  output reg zero_flag,
  output reg zero_flag_we,
  output reg wdog_expired_n,
  output reg sleep_flag_n,
  output reg watchdog_clear,
  output reg prescaler_clear
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CALL2 = 2'b10;
  reg rst_meta;
  reg rst_sync;
  reg [1:0] state;
  reg [1:0] next_state;
  wire [7:0] alu_result;
  wire alu_zero;
  wire take_op;
  reg [7:0] next_accumulator;
  reg [14:0] next_pc_out;
  reg next_pc_load;
  reg next_file_we;
  reg [6:0] next_file_waddr;
  reg [7:0] next_file_wdata;
  reg [14:0] next_stack_top;
  reg next_stack_push;
  reg next_zero_flag;
  reg next_zero_flag_we;
  reg next_wdog_expired_n;
  reg next_sleep_flag_n;
  reg next_watchdog_clear;
  reg next_prescaler_clear;

  // an op is only taken when idle and ready, so nothing slips in before ready rises after reset
  assign take_op = op_valid && op_ready && (state == ST_IDLE);

  // reset is released through two flops so all state leaves reset on one edge
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ccco_alu u_alu (
    .op(op_code),
    .operand(file_rdata),
    .result(alu_result),
    .zero(alu_zero)
  );

  function is_call;
    input [2:0] op;
    begin
      is_call = (op == `CCCO_OP_CALLACC);
    end
  endfunction

  function is_alu_op;
    input [2:0] op;
    begin
      is_alu_op = (op == `CCCO_OP_COMPF) || (op == `CCCO_OP_DECFILE);
    end
  endfunction

  always @* begin
    case (state)
      ST_IDLE: next_state = (take_op && is_call(op_code)) ? ST_CALL2 : ST_IDLE;
      ST_CALL2: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // watchdog side: one-cycle clear pulses, both status flags forced high
  always @* begin
    next_watchdog_clear = 1'b0;
    next_prescaler_clear = 1'b0;
    next_wdog_expired_n = wdog_expired_n;
    next_sleep_flag_n = sleep_flag_n;
    if (take_op && op_code == `CCCO_OP_CLRWD) begin
      next_watchdog_clear = 1'b1;
      next_prescaler_clear = 1'b1;
      next_wdog_expired_n = 1'b1;
      next_sleep_flag_n = 1'b1;
    end
  end

  // return address leaves on the taking edge, the target on the next one
  always @* begin
    next_stack_top = stack_top;
    next_stack_push = 1'b0;
    next_pc_out = pc_out;
    next_pc_load = 1'b0;
    if (take_op && is_call(op_code)) begin
      next_stack_top = pc_in + 15'h0001;
      next_stack_push = 1'b1;
    end
    if (state == ST_CALL2) begin
      // second cycle: target formed after the push; zero flag left alone
      next_pc_out = {pc_high_latch, accumulator};
      next_pc_load = 1'b1;
    end
  end

  always @* begin
    next_accumulator = accumulator;
    if (take_op && is_alu_op(op_code) && dest_sel == `CCCO_DEST_ACC) begin
      next_accumulator = alu_result;
    end else if (take_op && op_code == `CCCO_OP_CLRACC) begin
      next_accumulator = `CCCO_ZERO_BYTE;
    end
  end

  // address and data hold after the strobe so a slow file port can still latch them
  always @* begin
    next_file_we = 1'b0;
    next_file_waddr = file_waddr;
    next_file_wdata = file_wdata;
    if (take_op && is_alu_op(op_code) && dest_sel == `CCCO_DEST_FILE) begin
      next_file_we = 1'b1;
      next_file_waddr = file_addr;
      next_file_wdata = alu_result;
    end else if (take_op && op_code == `CCCO_OP_CLRFILE) begin
      next_file_we = 1'b1;
      next_file_waddr = file_addr;
      next_file_wdata = `CCCO_ZERO_BYTE;
    end
  end

  // only the zero flag is written here; wdog_expired_n and sleep_flag_n are set by the clear watchdog block
  always @* begin
    next_zero_flag = zero_flag;
    next_zero_flag_we = 1'b0;
    if (take_op) begin
      case (op_code)
        `CCCO_OP_COMPF, `CCCO_OP_DECFILE: begin
          next_zero_flag = alu_zero;
          next_zero_flag_we = 1'b1;
        end
        `CCCO_OP_CLRFILE, `CCCO_OP_CLRACC: begin
          next_zero_flag = 1'b1;
          next_zero_flag_we = 1'b1;
        end
        default: begin
          next_zero_flag_we = 1'b0;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_IDLE;
      op_ready <= 1'b0;
      accumulator <= `CCCO_ACC_RST;
      pc_out <= `CCCO_PC_RST;
      pc_load <= 1'b0;
      file_we <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= `CCCO_ZERO_BYTE;
      stack_top <= `CCCO_PC_RST;
      stack_push <= 1'b0;
      zero_flag <= 1'b0;
      zero_flag_we <= 1'b0;
      wdog_expired_n <= 1'b1;
      sleep_flag_n <= 1'b1;
      watchdog_clear <= 1'b0;
      prescaler_clear <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      // not ready during the second call cycle so fetch holds the next op
      op_ready <= (next_state == ST_IDLE);
      accumulator <= next_accumulator;
      pc_out <= next_pc_out;
      pc_load <= next_pc_load;
      file_we <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
      stack_top <= next_stack_top;
      stack_push <= next_stack_push;
      zero_flag <= next_zero_flag;
      zero_flag_we <= next_zero_flag_we;
      wdog_expired_n <= next_wdog_expired_n;
      sleep_flag_n <= next_sleep_flag_n;
      watchdog_clear <= next_watchdog_clear;
      prescaler_clear <= next_prescaler_clear;
    end
  end
endmodule

// ===== testbench/ccco_exec_chk.sv
// assertion checker for the execution block
`timescale 1ns/100ps
module ccco_exec_chk (
  input logic core_clk,
  input logic reset_n,
  input logic clk_en,
  input logic op_valid,
  input logic dest_sel,
  input logic op_ready,
  input logic pc_load,
  input logic file_we,
  input logic stack_push,
  input logic zero_flag,
  input logic zero_flag_we,
  input logic wdog_expired_n,
  input logic sleep_flag_n,
  input logic watchdog_clear,
  input logic prescaler_clear,
  input logic [2:0] op_code,
  input logic [6:0] file_addr,
  input logic [6:0] pc_high_latch,
  input logic [6:0] file_waddr,
  input logic [7:0] file_rdata,
  input logic [7:0] accumulator,
  input logic [7:0] file_wdata,
  input logic [14:0] pc_in,
  input logic [14:0] pc_out,
  input logic [14:0] stack_top
);
  logic tk;
  logic [7:0] dst;
  assign tk = clk_en && op_valid && op_ready;
  // file_we picks which copy of the result to judge
  assign dst = file_we ? file_wdata : accumulator;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wd_clear_a: assert property (tk && op_code == 3'h1 |=> watchdog_clear && prescaler_clear)
    else $error("no watchdog clear");
  wd_flags_a: assert property (tk && op_code == 3'h1 |=> wdog_expired_n && sleep_flag_n)
    else $error("flags not set");
  ret_push_a: assert property (tk && op_code == 3'h2 |=> stack_push && !op_ready &&
    stack_top == $past(pc_in) + 15'h1) else $error("bad push");
  call_load_a: assert property (tk && op_code == 3'h2 ##1 clk_en |=> pc_load && !zero_flag_we &&
    pc_out == {$past(pc_high_latch), $past(accumulator)}) else $error("bad target");
  call_len_a: assert property (tk && op_code == 3'h2 ##1 clk_en |=> op_ready) else $error("call length");
  busy_refuse_a: assert property (clk_en && op_valid && !op_ready && op_code == 3'h5 |=> !zero_flag_we &&
    accumulator == $past(accumulator)) else $error("op taken while busy");
  comp_dest_a: assert property (tk && op_code == 3'h3 |=> file_we == $past(dest_sel) &&
    dst == ~$past(file_rdata)) else $error("bad complement");
  clr_file_a: assert property (tk && op_code == 3'h4 |=> file_we && file_wdata == 8'h00 && zero_flag &&
    file_waddr == $past(file_addr)) else $error("bad file clear");
  clr_acc_a: assert property (tk && op_code == 3'h5 |=> accumulator == 8'h00 && zero_flag && zero_flag_we)
    else $error("bad acc clear");
  dec_dest_a: assert property (tk && op_code == 3'h6 |=> file_we == $past(dest_sel) &&
    dst == $past(file_rdata) - 8'h1) else $error("bad decrement");
  zero_upd_a: assert property (tk && (op_code == 3'h3 || op_code == 3'h6) |=> zero_flag_we &&
    zero_flag == (dst == 8'h00)) else $error("bad zero");
  enable_hold_a: assert property (!clk_en |=> $stable(accumulator) && $stable(pc_out) && $stable(op_ready) &&
    $stable(file_we) && $stable(zero_flag_we)) else $error("state moved while frozen");
  call_c: cover property (tk && op_code == 3'h2);
  freeze_c: cover property (tk ##1 !clk_en);
  dec_zero_c: cover property (tk && op_code == 3'h6 && file_rdata == 8'h01);
  comp_file_c: cover property (tk && op_code == 3'h3 && dest_sel);
endmodule
bind ccco_exec ccco_exec_chk u_chk (.*);

// ===== testbench/testbench.sv
// random and corner tests for the execution block
`timescale 1ns/100ps
module testbench;
  logic core_clk, reset_n, clk_en, op_valid, dest_sel, op_ready, pc_load, file_we, stack_push;
  logic zero_flag, zero_flag_we, wdog_expired_n, sleep_flag_n, watchdog_clear, prescaler_clear;
  logic [2:0] op_code;
  logic [6:0] file_addr, pc_high_latch, file_waddr;
  logic [7:0] file_rdata, accumulator, file_wdata, a;
  logic [14:0] pc_in, pc_out, stack_top;
  int err_count, checks_done, i;
  ccco_exec DUT (.*);
  task chk(input [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task finish_test;
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function [7:0] f(input [2:0] c, input [7:0] r);
    f = c == 3'h3 ? ~r : r - 8'h1;
  endfunction
  task op(input [2:0] c, input d, input [7:0] r);
    @(posedge core_clk);
    op_valid <= 1;
    op_code <= c;
    dest_sel <= d;
    file_rdata <= r;
    clk_en <= 1;
    {file_addr, pc_in, pc_high_latch} <= 29'($urandom);
    @(posedge core_clk);
    // a clear offered in the call's second cycle must be ignored
    op_valid <= c == 3'h2;
    op_code <= 3'h5;
    clk_en <= c == 3'h2 | $urandom % 4 > 0;
    #1;
    if (c == 3'h1) chk(wdog_expired_n & sleep_flag_n & watchdog_clear & prescaler_clear, 1);
    if (c == 3'h3 || c == 3'h6) begin
      chk(d ? file_wdata : accumulator, f(c, r));
      chk(file_we, d);
      if (d) chk(file_waddr, file_addr);
      chk(zero_flag, f(c, r) == 8'h00);
    end
    if (c == 3'h4) begin
      chk({file_we, file_wdata, zero_flag}, 16'h201);
      chk(file_waddr, file_addr);
    end
    if (c == 3'h5) chk({accumulator, zero_flag}, 1);
    if (c == 3'h2) begin
      a = accumulator;
      chk({stack_push, stack_top}, {1'b1, pc_in + 15'h1});
      @(posedge core_clk);
      op_valid <= 0;
      #1;
      chk(pc_out, {pc_high_latch, a});
      chk({pc_load, op_ready, stack_push, accumulator}, {3'b110, a});
    end
  endtask
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    err_count++;
    finish_test;
  end
  initial begin
    i = $urandom(32'ha21e7db7);
    {reset_n, clk_en, op_valid, op_code, file_addr, dest_sel, file_rdata, pc_high_latch, pc_in} = 0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1;
    clk_en <= 1;
    repeat (4) @(posedge core_clk);
    op(3'h6, 0, 8'h01);
    op(3'h6, 1, 8'h00);
    op(3'h3, 1, 8'hff);
    for (i = 1; i < 7; i++) op(3'(i), i[0], 8'h5a);
    repeat (200) op(3'($urandom % 7), 1'($urandom), 8'($urandom));
    finish_test;
  end
endmodule
